// ==== rtl/afg_consts.vh ====
// Purpose: constants for the amplifier fault and gain control block
// Assumes: 20 MHz controller clock, Avalon-MM word addressing, one offset per 32-bit word
// Notes: all offsets are word addresses of 32-bit registers
`ifndef AFG_CONSTS_VH
`define AFG_CONSTS_VH
`define AFG_CLK_HZ 20000000
`define AFG_PEAK_TIME_MS 1000
`define AFG_PEAK_CYCLES ((`AFG_CLK_HZ / 1000) * `AFG_PEAK_TIME_MS)
`define AFG_REG_CFG 4'h0
`define AFG_REG_TORQUE 4'h1
`define AFG_REG_CTRL 4'h2
`define AFG_REG_STATUS 4'h3
`define AFG_REG_GAIN 4'h4
`define AFG_REG_TCMD 4'h5
`define AFG_CFG_MT 0
`define AFG_CFG_BR 1
`define AFG_CFG_AG_LO 2
`define AFG_CFG_AU_LO 4
`define AFG_CFG_EXT 6
`define AFG_CTRL_MO 0
`define AFG_CTRL_SH 1
`define AFG_CTRL_CLR 2
`define AFG_CTRL_HANDLER 3
`define AFG_ERR_OC 0
`define AFG_ERR_OV 1
`define AFG_AG_04 8'h28
`define AFG_AG_07 8'h46
`define AFG_AG_10 8'h64
`endif

// ==== rtl/afg_peak_timer.v ====
// Purpose: peak torque time budget for one axis
// Assumes: budget counts whole clock cycles
// Notes: budget drains at peak, refills while below continuous limit
`timescale 1ns/1ps
module afg_peak_timer #(
  parameter W = 26,
  parameter [W-1:0] MAX = 26'd20000000
)(
  input wire i_mclk,
  input wire i_rst,
  input wire i_above_cont,
  input wire i_below_cont,
  output wire o_peak_ok
);
  reg [W-1:0] budget_ff;
  reg [W-1:0] nxt_budget;
  // Drain at peak, refill below continuous, hold in between
  always @*
  begin
    nxt_budget = budget_ff;
    if (i_above_cont && budget_ff != {W{1'b0}})
      nxt_budget = budget_ff - {{(W-1){1'b0}}, 1'b1}; // RULE_08
    else if (i_below_cont && budget_ff != MAX)
      nxt_budget = budget_ff + {{(W-1){1'b0}}, 1'b1}; // RULE_09
  end
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      budget_ff <= MAX;
    else
      budget_ff <= nxt_budget;
  end
  assign o_peak_ok = (budget_ff != {W{1'b0}});
endmodule

// ==== rtl/afg_top.v ====
// Purpose: one axis of amplifier config, peak torque limiting and fault latch
// Assumes: one 20 MHz clock; fault pins asynchronous, three-stage synchronised
// Notes: registers on Avalon-MM, one wait cycle per access
// Functional notes
// (RULE_01) Host sets brushless motor type to 1
// (RULE_02) Brushed: host sets type and brushed flag
// (RULE_03) Gain code 0/1/2 is 0.4/0.7/1.0 A/V
// (RULE_04) Host idles axis before gain write
// (RULE_05) Host idles axis before current-loop write
// (RULE_06) Current-loop code selects mode and gain
// (RULE_07) Host picks current-loop code by inductance
// (RULE_08) Peak torque at most one second
// (RULE_09) Time below continuous extends peak allowance
// (RULE_10) Error query returns 8-bit fault bitmask
// (RULE_11) Query reports latch per bank separately
// (RULE_12) Any fault starts user fault handler
// (RULE_13) Short circuit latches overcurrent, disables stage
// (RULE_14) Overvoltage unlatched, phases shorted while present
// (RULE_15) External amplifier axis reports no faults
// (RULE_16) Latch only while bank has servo-here axis
// (RULE_17) Host halts, idles, then clears latch
// (RULE_18) Latched bit holds until clear sequence
`timescale 1ns/1ps
`include "afg_consts.vh"
module afg_top #(
  parameter PEAK_CYCLES = `AFG_PEAK_CYCLES,
  parameter TW = 16
)(
  input wire i_mclk,
  input wire i_rst,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_short_circuit,
  input wire i_over_voltage,
  input wire i_bank2_latched,
  output reg o_stage_enable,
  output reg o_phase_short,
  output reg o_brushed,
  output reg o_commutate,
  output reg [7:0] o_amp_gain_ma_v,
  output reg o_chopper_mode,
  output reg o_high_loop_gain,
  output reg [TW-1:0] o_torque_command,
  output reg o_fault_handler_start
);
  // Configuration, control and limits
  reg motor_type_select_ff;
  reg commutation_off_flag_ff;
  reg [1:0] amp_gain_setting_ff;
  reg [1:0] current_loop_gain_ff;
  reg ext_amp_ff;
  reg power_stage_idle_ff;
  reg servo_here_state_ff;
  reg handler_present_ff;
  reg [TW-1:0] peak_torque_limit_ff;
  reg [TW-1:0] continuous_torque_limit_ff;
  reg [TW-1:0] torque_request_ff;
  reg [7:0] latched_ff;
  reg any_fault_d_ff;
  reg ack_ff;
  // Three-stage synchronisers for the fault pins
  reg [2:0] oc_sync_ff;
  reg [2:0] ov_sync_ff;
  reg [2:0] b2_sync_ff;
  reg oc_ff;
  reg ov_ff;
  reg b2_ff;
  wire peak_ok;
  wire [TW-1:0] active_limit;
  wire [TW-1:0] clamped;
  wire above_cont;
  wire below_cont;
  wire wr_hit;
  wire rd_hit;
  wire [7:0] live_bits;
  wire [7:0] fault_mask;
  wire any_fault;
  wire bank1_latched;
  wire clear_req;
  reg [31:0] nxt_rdata;
  // One access per two cycles; a write commits only at the edge where waitrequest is seen low
  assign wr_hit = i_avs_write && ack_ff;
  assign rd_hit = i_avs_read && !ack_ff;
  // Clear only from motor-off; the hazard is dropping a fault under power
  assign clear_req = wr_hit && i_avs_address == `AFG_REG_CTRL && i_avs_byteenable[0] &&
    i_avs_writedata[`AFG_CTRL_CLR] && power_stage_idle_ff;
  // Synchronise asynchronous inputs; a level counts once stages 2 and 3 agree
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      oc_sync_ff <= 3'h0;
      ov_sync_ff <= 3'h0;
      b2_sync_ff <= 3'h0;
      oc_ff <= 1'b0;
      ov_ff <= 1'b0;
      b2_ff <= 1'b0;
    end
    else
    begin
      oc_sync_ff <= {oc_sync_ff[1:0], i_short_circuit};
      ov_sync_ff <= {ov_sync_ff[1:0], i_over_voltage};
      b2_sync_ff <= {b2_sync_ff[1:0], i_bank2_latched};
      if (oc_sync_ff[1] == oc_sync_ff[2])
        oc_ff <= oc_sync_ff[2];
      if (ov_sync_ff[1] == ov_sync_ff[2])
        ov_ff <= ov_sync_ff[2];
      if (b2_sync_ff[1] == b2_sync_ff[2])
        b2_ff <= b2_sync_ff[2];
    end
  end
  // Live fault bits, hidden entirely for an external amplifier
  assign live_bits = {6'h00, ov_ff, oc_ff};
  assign fault_mask = ext_amp_ff ? 8'h00 : live_bits; // RULE_15
  // Overcurrent latches only while servo-here; set beats clear
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      latched_ff <= 8'h00;
    else if (fault_mask[`AFG_ERR_OC] && servo_here_state_ff) // RULE_13 RULE_16
      latched_ff <= latched_ff | 8'h01;
    else if (clear_req)
      latched_ff <= 8'h00; // RULE_18
  end
  assign bank1_latched = |latched_ff; // RULE_11
  assign any_fault = |(fault_mask | latched_ff);
  // Register writes; gain codes ignored unless the stage is idle
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      motor_type_select_ff <= 1'b0;
      commutation_off_flag_ff <= 1'b0;
      amp_gain_setting_ff <= 2'h0;
      current_loop_gain_ff <= 2'h0;
      ext_amp_ff <= 1'b0;
      power_stage_idle_ff <= 1'b1;
      servo_here_state_ff <= 1'b0;
      handler_present_ff <= 1'b0;
      peak_torque_limit_ff <= {TW{1'b0}};
      continuous_torque_limit_ff <= {TW{1'b0}};
      torque_request_ff <= {TW{1'b0}};
    end
    else if (wr_hit && i_avs_byteenable[0])
    begin
      case (i_avs_address)
        `AFG_REG_CFG:
        begin
          motor_type_select_ff <= i_avs_writedata[`AFG_CFG_MT];
          commutation_off_flag_ff <= i_avs_writedata[`AFG_CFG_BR];
          ext_amp_ff <= i_avs_writedata[`AFG_CFG_EXT];
          if (power_stage_idle_ff)
          begin
            amp_gain_setting_ff <= i_avs_writedata[`AFG_CFG_AG_LO+1:`AFG_CFG_AG_LO]; // RULE_04
            current_loop_gain_ff <= i_avs_writedata[`AFG_CFG_AU_LO+1:`AFG_CFG_AU_LO]; // RULE_05
          end
        end
        `AFG_REG_TORQUE:
        begin
          continuous_torque_limit_ff <= i_avs_writedata[TW-1:0];
          peak_torque_limit_ff <= i_avs_writedata[TW+15:16];
        end
        `AFG_REG_CTRL:
        begin
          power_stage_idle_ff <= i_avs_writedata[`AFG_CTRL_MO];
          servo_here_state_ff <= i_avs_writedata[`AFG_CTRL_SH] & ~i_avs_writedata[`AFG_CTRL_MO];
          handler_present_ff <= i_avs_writedata[`AFG_CTRL_HANDLER];
        end
        `AFG_REG_TCMD:
          torque_request_ff <= i_avs_writedata[TW-1:0];
        default:
          motor_type_select_ff <= motor_type_select_ff;
      endcase
    end
  end
  // Peak allowance timer; drains above continuous, refills below
  assign above_cont = torque_request_ff > continuous_torque_limit_ff;
  assign below_cont = torque_request_ff < continuous_torque_limit_ff;
  afg_peak_timer #(
    .W(26),
    .MAX(PEAK_CYCLES[25:0])
  ) u_peak (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_above_cont(above_cont),
    .i_below_cont(below_cont),
    .o_peak_ok(peak_ok)
  );
  assign active_limit = peak_ok ? peak_torque_limit_ff : continuous_torque_limit_ff; // RULE_08
  assign clamped = (torque_request_ff > active_limit) ? active_limit : torque_request_ff;
  // Read mux; unmapped addresses read zero
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    case (i_avs_address)
      `AFG_REG_CFG:
        nxt_rdata = {25'h0, ext_amp_ff, current_loop_gain_ff, amp_gain_setting_ff,
          commutation_off_flag_ff, motor_type_select_ff};
      `AFG_REG_TORQUE:
        nxt_rdata = {peak_torque_limit_ff, continuous_torque_limit_ff};
      `AFG_REG_CTRL:
        nxt_rdata = {28'h0, handler_present_ff, 1'b0, servo_here_state_ff, power_stage_idle_ff};
      `AFG_REG_STATUS:
        nxt_rdata = {22'h0, b2_ff, bank1_latched, fault_mask | latched_ff}; // RULE_10 RULE_11
      `AFG_REG_GAIN:
        nxt_rdata = {24'h0, o_amp_gain_ma_v};
      `AFG_REG_TCMD:
        nxt_rdata = {{(32-TW){1'b0}}, o_torque_command};
      default:
        nxt_rdata = 32'h0000_0000;
    endcase
  end
  // Bus answer and registered outputs
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ack_ff <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      o_stage_enable <= 1'b0;
      o_phase_short <= 1'b0;
      o_brushed <= 1'b0;
      o_commutate <= 1'b0;
      o_amp_gain_ma_v <= `AFG_AG_04;
      o_chopper_mode <= 1'b0;
      o_high_loop_gain <= 1'b0;
      o_torque_command <= {TW{1'b0}};
      o_fault_handler_start <= 1'b0;
      any_fault_d_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= (i_avs_read || i_avs_write) && !ack_ff;
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_ff);
      if (rd_hit)
        o_avs_readdata <= nxt_rdata;
      // Stage off when idle, external, overvoltage present, or overcurrent live or latched
      o_stage_enable <= !power_stage_idle_ff && !latched_ff[`AFG_ERR_OC] &&
        !fault_mask[`AFG_ERR_OC] && !fault_mask[`AFG_ERR_OV] && !ext_amp_ff; // RULE_13 RULE_14
      o_phase_short <= fault_mask[`AFG_ERR_OV]; // RULE_14
      o_brushed <= motor_type_select_ff & commutation_off_flag_ff;
      o_commutate <= motor_type_select_ff & ~commutation_off_flag_ff;
      case (amp_gain_setting_ff) // RULE_03
        2'h1: o_amp_gain_ma_v <= `AFG_AG_07;
        2'h2: o_amp_gain_ma_v <= `AFG_AG_10;
        default: o_amp_gain_ma_v <= `AFG_AG_04;
      endcase
      // Code in half steps: bit0 chopper, bit1 higher gain
      o_chopper_mode <= current_loop_gain_ff[0]; // RULE_06
      o_high_loop_gain <= current_loop_gain_ff[1]; // RULE_06
      o_torque_command <= (power_stage_idle_ff || fault_mask[`AFG_ERR_OV]) ? {TW{1'b0}} : clamped;
      any_fault_d_ff <= any_fault;
      o_fault_handler_start <= any_fault && !any_fault_d_ff && handler_present_ff; // RULE_12
    end
  end
endmodule

// ==== bench/afg_checker_assertions.sv ====
// Purpose: port checks for afg_top
// Assumes: one clock, async reset high
// Notes: fault pins need up to 5 cycles
`timescale 1ns/1ps
module afg_checker #(
  parameter TW = 16
)(
  input wire i_mclk,
  input wire i_rst,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire i_short_circuit,
  input wire i_over_voltage,
  input wire o_stage_enable,
  input wire o_phase_short,
  input wire [7:0] o_amp_gain_ma_v,
  input wire [TW-1:0] o_torque_command,
  input wire o_fault_handler_start
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Six cycles covers the synchroniser latency
  property p_oc_off; i_short_circuit [*6] |-> !o_stage_enable; endproperty
  a_oc_off: assert property (p_oc_off) else $error("stage on under short");
  property p_ov_on; i_over_voltage [*6] |-> o_phase_short && o_torque_command == 0; endproperty
  a_ov_on: assert property (p_ov_on) else $error("phases not shorted");
  property p_ov_off; !i_over_voltage [*6] |-> !o_phase_short; endproperty
  a_ov_off: assert property (p_ov_off) else $error("phases stay shorted");
  property p_hs_pulse; o_fault_handler_start |=> !o_fault_handler_start; endproperty
  a_hs_pulse: assert property (p_hs_pulse) else $error("handler start too long");
  property p_gain; o_amp_gain_ma_v == 8'h28 || o_amp_gain_ma_v == 8'h46 || o_amp_gain_ma_v == 8'h64; endproperty
  a_gain: assert property (p_gain) else $error("gain off table");
  property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("ack longer than one cycle");
  property p_ack; (i_avs_read || i_avs_write) |-> ##[0:2] !o_avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_rd_hold; !i_avs_read |=> $stable(o_avs_readdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind afg_top afg_checker #(.TW(TW)) i_chk (.i_mclk, .i_rst, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .i_short_circuit, .i_over_voltage, .o_stage_enable, .o_phase_short,
  .o_amp_gain_ma_v, .o_torque_command, .o_fault_handler_start);

// ==== bench/afg_stage_model.sv ====
// Purpose: power stage fault pin model
// Assumes: faults are injected by the bench
// Notes: pins change only after a clock edge
`timescale 1ns/1ps
module afg_stage_model (
  input wire i_mclk,
  input wire i_make_short,
  input wire i_make_ov,
  input wire i_bank2,
  output reg o_short_circuit = 1'b0,
  output reg o_over_voltage = 1'b0,
  output reg o_bank2_latched = 1'b0
);
  // Registered so pins never move on the sampling edge
  always @(posedge i_mclk)
  begin
    o_short_circuit <= i_make_short;
    o_over_voltage <= i_make_ov;
    o_bank2_latched <= i_bank2;
  end
endmodule

// ==== bench/afg_top_tb.sv ====
// Purpose: self-checking bench for afg_top
// Assumes: short peak budget of 100 cycles
// Notes: host side is the bench, far side the stage model
`timescale 1ns/1ps
`include "afg_consts.vh"
module afg_top_tb;
  reg i_mclk = 1'b0;
  reg i_rst = 1'b1;
  reg [3:0] i_avs_address = 4'h0;
  reg i_avs_read = 1'b0;
  reg i_avs_write = 1'b0;
  reg [31:0] i_avs_writedata = 32'h0;
  reg mk_sc = 1'b0;
  reg mk_ov = 1'b0;
  reg bk2 = 1'b0;
  wire i_short_circuit, i_over_voltage, i_bank2_latched, o_avs_waitrequest, o_stage_enable, o_phase_short;
  wire o_brushed, o_commutate, o_chopper_mode, o_high_loop_gain, o_fault_handler_start;
  wire [31:0] o_avs_readdata;
  wire [7:0] o_amp_gain_ma_v;
  wire [15:0] o_torque_command;
  integer failures = 0;
  integer checks = 0;
  integer cyc = 0;
  integer pulses = 0;
  reg [31:0] r;
  afg_top #(.PEAK_CYCLES(100), .TW(16)) i_dut (.i_mclk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable(4'hF), .o_avs_readdata, .o_avs_waitrequest, .i_short_circuit,
    .i_over_voltage, .i_bank2_latched, .o_stage_enable, .o_phase_short, .o_brushed, .o_commutate,
    .o_amp_gain_ma_v, .o_chopper_mode, .o_high_loop_gain, .o_torque_command, .o_fault_handler_start);
  afg_stage_model i_stage (.i_mclk, .i_make_short(mk_sc), .i_make_ov(mk_ov), .i_bank2(bk2),
    .o_short_circuit(i_short_circuit), .o_over_voltage(i_over_voltage), .o_bank2_latched(i_bank2_latched));
  always #25 i_mclk = ~i_mclk;
  task wrap_up;
  begin
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // Handler pulse count and hang guard; run needs about 460 cycles
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (o_fault_handler_start === 1'b1)
      pulses <= pulses + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      wrap_up;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  // Held until waitrequest is sampled low, read data taken there
  task bus(input w, input [3:0] a, input [31:0] d);
  begin
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= ~w;
    @(posedge i_mclk);
    while (o_avs_waitrequest !== 1'b0)
      @(posedge i_mclk);
    r = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  end
  endtask
  task t_gain;
    integer k;
    reg [31:0] e;
  begin
    bus(1, `AFG_REG_CTRL, 32'h1);
    for (k = 0; k < 4; k = k + 1)
    begin
      bus(1, `AFG_REG_CFG, (k << 4) | ((k % 3) << 2));
      repeat (2) @(posedge i_mclk);
      e = (k % 3 == 0) ? `AFG_AG_04 : (k % 3 == 1) ? `AFG_AG_07 : `AFG_AG_10;
      chk({24'h0, o_amp_gain_ma_v}, e);
      chk({o_high_loop_gain, o_chopper_mode}, k);
    end
    bus(1, `AFG_REG_CFG, 32'h1);
    repeat (2) @(posedge i_mclk);
    chk({o_brushed, o_commutate}, 32'h1);
    bus(1, `AFG_REG_CFG, 32'h3);
    repeat (2) @(posedge i_mclk);
    chk({o_brushed, o_commutate}, 32'h2);
    bus(1, `AFG_REG_CTRL, 32'h0);
    bus(1, `AFG_REG_CFG, 32'hB);
    repeat (2) @(posedge i_mclk);
    chk({24'h0, o_amp_gain_ma_v}, `AFG_AG_04);
    $display("gain test done");
  end
  endtask
  task t_peak;
  begin
    bus(1, `AFG_REG_TORQUE, {16'h00C8, 16'h0064});
    bus(1, `AFG_REG_CTRL, 32'h2);
    bus(1, `AFG_REG_TCMD, 32'h96);
    repeat (20) @(posedge i_mclk);
    chk(o_torque_command, 32'h96);
    chk(o_stage_enable, 1'b1);
    repeat (100) @(posedge i_mclk);
    chk(o_torque_command, 32'h64);
    bus(1, `AFG_REG_TCMD, 32'h32);
    repeat (60) @(posedge i_mclk);
    bus(1, `AFG_REG_TCMD, 32'h96);
    repeat (20) @(posedge i_mclk);
    chk(o_torque_command, 32'h96);
    repeat (60) @(posedge i_mclk);
    chk(o_torque_command, 32'h64);
    $display("peak test done");
  end
  endtask
  task t_ov;
  begin
    bus(1, `AFG_REG_TCMD, 32'h32);
    mk_ov <= 1'b1;
    repeat (8) @(posedge i_mclk);
    chk({o_phase_short, o_torque_command}, 32'h10000);
    bus(0, `AFG_REG_STATUS, 32'h0);
    chk(r, 32'h2);
    mk_ov <= 1'b0;
    repeat (8) @(posedge i_mclk);
    chk({o_phase_short, o_torque_command}, 32'h32);
    bus(0, `AFG_REG_STATUS, 32'h0);
    chk(r, 32'h0);
    $display("overvoltage test done");
  end
  endtask
  task t_oc;
    integer p0;
  begin
    bus(1, `AFG_REG_CTRL, 32'h9);
    mk_sc <= 1'b1;
    repeat (8) @(posedge i_mclk);
    bus(0, `AFG_REG_STATUS, 32'h0);
    chk(r, 32'h1);
    mk_sc <= 1'b0;
    repeat (8) @(posedge i_mclk);
    bus(1, `AFG_REG_CTRL, 32'hA);
    p0 = pulses;
    mk_sc <= 1'b1;
    repeat (8) @(posedge i_mclk);
    bus(0, `AFG_REG_STATUS, 32'h0);
    chk(r, 32'h101);
    chk(o_stage_enable, 1'b0);
    chk(pulses != p0, 1);
    mk_sc <= 1'b0;
    repeat (8) @(posedge i_mclk);
    bus(0, `AFG_REG_STATUS, 32'h0);
    chk(r, 32'h101);
    bus(1, `AFG_REG_CTRL, 32'h9);
    bus(1, `AFG_REG_CTRL, 32'hD);
    repeat (8) @(posedge i_mclk);
    bus(0, `AFG_REG_STATUS, 32'h0);
    chk(r, 32'h0);
    $display("overcurrent test done");
  end
  endtask
  task t_ext;
  begin
    bus(1, `AFG_REG_CFG, 32'h41);
    bus(1, `AFG_REG_CTRL, 32'h2);
    mk_sc <= 1'b1;
    repeat (8) @(posedge i_mclk);
    bus(0, `AFG_REG_STATUS, 32'h0);
    chk(r, 32'h0);
    mk_sc <= 1'b0;
    bus(1, `AFG_REG_CTRL, 32'h1);
    bus(1, `AFG_REG_CFG, 32'h1);
    bk2 <= 1'b1;
    repeat (8) @(posedge i_mclk);
    bus(0, `AFG_REG_STATUS, 32'h0);
    chk(r, 32'h200);
    bus(1, 4'hF, 32'h5A);
    bus(0, 4'hF, 32'h0);
    chk(r, 32'h0);
    $display("external and bank test done");
  end
  endtask
  initial
  begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_gain;
    t_peak;
    t_ov;
    t_oc;
    t_ext;
    wrap_up;
  end
endmodule
